// [bench/rrb_assertions.sv]
// port checker for the readback bank
`timescale 1ns/1ps
module rrb_assertions (input logic clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o,
    input logic pslverr_o, output0_update_o, input logic [3:0] pstrb_i,
    input logic [7:0] alert_flags_i, output0_trigger_select_o, input logic [11:0] paddr_i,
    input logic [31:0] pwdata_i, prdata_o);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire tk = psel_i && penable_i && !pready_o;
    wire ws = tk && pwrite_i && paddr_i == 12'h30c && pstrb_i[0];
    sequence pulse_s; pready_o ##1 !pready_o; endsequence
    ready_one_a: assert property (tk |=> pulse_s) else $error("late ready");
    upper_zero_a: assert property (pready_o |-> !prdata_o[31:8]) else $error("upper");
    err_ready_a: assert property (pslverr_o |-> pready_o) else $error("stray err");
    align_err_a: assert property (pready_o && paddr_i[1:0] |-> pslverr_o)
        else $error("no err");
    sel_write_a: assert property (ws |=> output0_trigger_select_o == $past(pwdata_i[7:0]))
        else $error("sel write");
    sel_hold_a: assert property (!ws |=> $stable(output0_trigger_select_o))
        else $error("sel hold");
    alert_update_a: assert property (output0_update_o ==
        $past(|(alert_flags_i & output0_trigger_select_o))) else $error("update");
    rdata_hold_a: assert property (!(tk && !pwrite_i) |=> $stable(prdata_o))
        else $error("rdata");
endmodule : rrb_assertions
bind rrb_bank rrb_assertions i_rrb_assertions (.*);

// [bench/testbench.sv]
// bench for the readback bank
`timescale 1ns/1ps
module testbench;
    import rrb_pkg::*;
    logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic conv_done_i = 0, pready_o, pslverr_o, output0_update_o, exp_u = 0, e;
    logic [2:0] conv_channel_i = 0;
    logic [3:0] pstrb_i = 4'hf;
    logic [7:0] alert_flags_i = 0, sel_m = 0, output0_trigger_select_o;
    logic [11:0] paddr_i = 0;
    logic [15:0] conv_result_i = 0, res_m [8] = '{default: 0};
    logic [31:0] pwdata_i = 0, prdata_o, r;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    rrb_bank i_rrb_bank (.*);
    initial forever #12.5 clk_i = ~clk_i;
    task stop_test;
        if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task chk(input string n, input logic [31:0] x, g);
        num_checks++;
        if (g !== x) error_cnt++;
        if (g !== x) $display("CHECK FAILED %s exp %h got %h", n, x, g);
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s = 4'hf);
        @(posedge clk_i) {psel_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} <= {1'b1, w, a, d, s};
        @(posedge clk_i) penable_i <= 1;
        @(posedge clk_i) if (w && a == 12'h30c && s[0]) sel_m <= d[7:0];
        while (pready_o !== 1'b1) @(posedge clk_i);
        {r, e} = {prdata_o, pslverr_o};
        {psel_i, penable_i} <= 2'b00;
    endtask : apb
    always @(posedge clk_i)
    begin
        if (!rst_i) chk("update", 32'(exp_u), 32'(output0_update_o));
        if (!rst_i) chk("trigsel", 32'(sel_m), 32'(output0_trigger_select_o));
        exp_u = !rst_i && |(alert_flags_i & sel_m);
        if (conv_done_i && conv_channel_i >= FIRST_CH) res_m[conv_channel_i] = conv_result_i;
        alert_flags_i <= 8'($urandom);
        error_cnt += (++cyc == 4000);
        if (cyc == 4000) stop_test;
    end
    initial
    begin
        void'($urandom(32'h5bfaea4e));
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        repeat (4)
        begin
            for (int i = 0; i < 12; i++)
            begin
                apb(0, {2'b00, IDX_CH2_LOW + 8'(i), 2'b00}, 0);
                chk("result", {24'h0, res_m[2 + i / 2][i[0] * 8 +: 8]}, r);
            end
            apb(0, 12'h30c, 0);
            chk("select", 32'(sel_m), r);
            for (int k = 0; k < 9; k++) @(posedge clk_i)
                {conv_done_i, conv_channel_i, conv_result_i} <= {1'b1, 19'($urandom)};
            @(posedge clk_i) conv_done_i <= 0;
            apb(1, {2'b00, IDX_CH2_LOW + 8'($urandom_range(11)), 2'b00}, $urandom);
            apb(1, 12'h30c, $urandom, 4'($urandom));
        end
        apb(1, 12'h30d, 32'hff);
        chk("error", 1, 32'(e));
        stop_test;
    end
endmodule : testbench

// [core/rrb_bank.sv]
// recent-result readback bank with output-0 trigger select, APB slave
// Function
// R1: each channel's high-byte register shows the top eight bits of its latest result.
// R2: each channel's low-byte register shows the next eight bits of its latest result.
// R3: after reset every result register reads zero until that channel converts.
// R4: each channel's low byte sits at an even index and its high byte at the next odd one, ch7 last.
// R5: an eight-bit read/write output-0 trigger-select register resets to zero.
// R6: a set select bit lets that channel's alert flag trigger an update of output 0.
// R7: both bytes of a pair update together on conversion and host writes to them do nothing.
`timescale 1ns/1ps
module rrb_bank
(
    input  wire logic                            clk_i,
    input  wire logic                            rst_i,
    input  wire logic                            psel_i,
    input  wire logic                            penable_i,
    input  wire logic                            pwrite_i,
    input  wire logic [rrb_pkg::ADDR_W-1:0]      paddr_i,
    input  wire logic [rrb_pkg::DATA_W-1:0]      pwdata_i,
    input  wire logic [rrb_pkg::STRB_W-1:0]      pstrb_i,
    output logic      [rrb_pkg::DATA_W-1:0]      prdata_o,
    output logic                                 pready_o,
    output logic                                 pslverr_o,
    input  wire logic                            conv_done_i,
    input  wire logic [rrb_pkg::CH_W-1:0]        conv_channel_i,
    input  wire logic [rrb_pkg::RESULT_W-1:0]    conv_result_i,
    input  wire logic [rrb_pkg::ALERT_W-1:0]     alert_flags_i,
    output logic      [rrb_pkg::REG_W-1:0]       output0_trigger_select_o,
    output logic                                 output0_update_o
);
    import rrb_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    logic [REG_W-1:0]    trig_sel_ff;
    logic [DATA_W-1:0]   prdata_ff;
    logic                pready_ff;
    logic                pslverr_ff;
    logic                update_ff;

    // ************************************************************
    // apb phase decode
    // ************************************************************
    // pready_ff masks the second access edge, so each transfer is taken once
    wire logic             access_w   = psel_i & penable_i & ~pready_ff;
    wire logic             rd_acc_w   = access_w & ~pwrite_i;
    wire logic             wr_acc_w   = access_w & pwrite_i;

    // ************************************************************
    // address decode
    // ************************************************************
    wire logic             lane_ok_w  = (paddr_i[1:0] == 2'h0);
    wire logic             top_ok_w   = (paddr_i[11:10] == 2'h0);
    wire logic             aligned_w  = lane_ok_w & top_ok_w;
    wire logic [IDX_W-1:0] idx_w      = paddr_i[9:2];
    wire logic             above_lo_w = (idx_w >= IDX_CH2_LOW);
    wire logic             below_hi_w = (idx_w <= IDX_CH7_HIGH);
    wire logic             hit_res_w  = aligned_w & above_lo_w & below_hi_w;
    wire logic             hit_trig_w = aligned_w & (idx_w == IDX_TRIG_SEL);
    wire logic             unmapped_w = ~(hit_res_w | hit_trig_w);
    wire logic [IDX_W-1:0] slot_w     = idx_w - IDX_CH2_LOW;
    // pairs are low-then-high, so bit 0 of the slot picks the byte [R4]
    wire logic [CH_W-1:0]  rd_ch_w    = hit_res_w ? slot_w[3:1] : 3'h0;
    wire logic             rd_high_w  = slot_w[0];

    // ************************************************************
    // conversion capture
    // ************************************************************
    // channels below the first one have no storage here and are dropped
    wire logic             conv_ok_w  = conv_done_i & (conv_channel_i >= FIRST_CH);
    wire logic [CH_W-1:0]  conv_idx_w = conv_channel_i - FIRST_CH;

    // ************************************************************
    // per-channel result pairs
    // ************************************************************
    logic [REG_W-1:0]      ch_rd_byte_w [NUM_CH];

    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        localparam logic [CH_W-1:0] CH_SLOT = CH_W'(c);

        logic [REG_W-1:0]  high_ff;
        logic [REG_W-1:0]  low_ff;

        // both bytes share one strobe, so a read never sees a torn pair [R7]
        wire logic         capture_w = conv_ok_w & (conv_idx_w == CH_SLOT);
        wire logic         picked_w  = hit_res_w & (rd_ch_w == CH_SLOT);
        wire logic [REG_W-1:0] byte_w = rd_high_w ? high_ff   // [R1]
                                                  : low_ff;   // [R2]

        always_ff @(posedge clk_i or posedge rst_i)
        begin
            if (rst_i)
            begin
                high_ff <= RESULT_RST[HIGH_MSB:HIGH_LSB];  // [R3]
                low_ff  <= RESULT_RST[LOW_MSB:LOW_LSB];    // [R3]
            end
            else if (capture_w)
            begin
                high_ff <= conv_result_i[HIGH_MSB:HIGH_LSB];  // [R1]
                low_ff  <= conv_result_i[LOW_MSB:LOW_LSB];    // [R2]
            end
        end

        assign ch_rd_byte_w[c] = picked_w ? byte_w : 8'h00;
    end

    // ************************************************************
    // read selection
    // ************************************************************
    // at most one channel is picked, so an or across the lanes is the mux
    logic [REG_W-1:0]      res_chain_w [NUM_CH+1];

    assign res_chain_w[0] = 8'h00;

    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_or
        assign res_chain_w[c+1] = res_chain_w[c] | ch_rd_byte_w[c];
    end

    wire logic [REG_W-1:0]  res_byte_w  = res_chain_w[NUM_CH];
    wire logic [REG_W-1:0]  trig_byte_w = hit_trig_w ? trig_sel_ff : 8'h00;
    wire logic [REG_W-1:0]  rd_byte_w   = res_byte_w | trig_byte_w;
    wire logic [DATA_W-1:0] nxt_prdata  = {24'h00_0000, rd_byte_w};

    // ************************************************************
    // write decode and trigger
    // ************************************************************
    // writes to result registers decode to nothing [R7]
    wire logic             trig_we_w    = wr_acc_w & hit_trig_w & pstrb_i[0];
    wire logic [REG_W-1:0] nxt_trig_sel = pwdata_i[REG_W-1:0];
    wire logic             nxt_pslverr  = access_w & unmapped_w;
    wire logic             alert_hit_w  = |(alert_flags_i & trig_sel_ff);  // [R6]

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            trig_sel_ff <= TRIG_RST;  // [R5]
        end
        else if (trig_we_w)
        begin
            trig_sel_ff <= nxt_trig_sel;  // [R5]
        end
    end

    // one wait state: answer lands one edge after the access phase opens
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pready_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= access_w;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pslverr_ff <= nxt_pslverr;
        end
    end

    // read data holds between reads, so a slow master can still pick it up
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prdata_ff <= RDATA_RST;
        end
        else if (rd_acc_w)
        begin
            prdata_ff <= nxt_prdata;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            update_ff <= 1'b0;
        end
        else
        begin
            update_ff <= alert_hit_w;  // [R6]
        end
    end

    assign prdata_o                 = prdata_ff;
    assign pready_o                 = pready_ff;
    assign pslverr_o                = pslverr_ff;
    assign output0_trigger_select_o = trig_sel_ff;
    assign output0_update_o         = update_ff;

endmodule : rrb_bank

// [include/rrb_pkg.sv]
// constants shared by the recent-result readback bank
package rrb_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int unsigned ADDR_W   = 12;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned STRB_W   = 4;
    localparam int unsigned REG_W    = 8;
    localparam int unsigned RESULT_W = 16;
    localparam int unsigned CH_W     = 3;
    localparam int unsigned IDX_W    = 8;
    localparam int unsigned NUM_CH   = 6;
    localparam int unsigned ALERT_W  = 8;

    // ************************************************************
    // register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [IDX_W-1:0] IDX_CH2_LOW  = 8'ha4;
    localparam logic [IDX_W-1:0] IDX_CH2_HIGH = 8'ha5;
    localparam logic [IDX_W-1:0] IDX_CH3_LOW  = 8'ha6;
    localparam logic [IDX_W-1:0] IDX_CH3_HIGH = 8'ha7;
    localparam logic [IDX_W-1:0] IDX_CH4_LOW  = 8'ha8;
    localparam logic [IDX_W-1:0] IDX_CH4_HIGH = 8'ha9;
    localparam logic [IDX_W-1:0] IDX_CH5_LOW  = 8'haa;
    localparam logic [IDX_W-1:0] IDX_CH5_HIGH = 8'hab;
    localparam logic [IDX_W-1:0] IDX_CH6_LOW  = 8'hac;
    localparam logic [IDX_W-1:0] IDX_CH6_HIGH = 8'had;
    localparam logic [IDX_W-1:0] IDX_CH7_LOW  = 8'hae;
    localparam logic [IDX_W-1:0] IDX_CH7_HIGH = 8'haf;
    localparam logic [IDX_W-1:0] IDX_TRIG_SEL = 8'hc3;

    // ************************************************************
    // field layout, channel range and reset values
    // ************************************************************
    localparam int unsigned HIGH_MSB = 15;
    localparam int unsigned HIGH_LSB = 8;
    localparam int unsigned LOW_MSB  = 7;
    localparam int unsigned LOW_LSB  = 0;
    localparam logic [CH_W-1:0]     FIRST_CH   = 3'h2;
    localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
    localparam logic [REG_W-1:0]    TRIG_RST   = 8'h00;
    localparam logic [DATA_W-1:0]   RDATA_RST  = 32'h0000_0000;

endpackage : rrb_pkg
